// *** src/gpib_remote_local_status.sv ***
// instrument side interface message handler: addressing, clears, trigger, poll, remote/local, events
// assumes bus bytes arrive decoded as one-cycle strobes synchronous to clock_in
`include "gpib_rl_params.svh"
module gpib_remote_local_status #(
    parameter int unsigned RTL_TIMEOUT_CYCLES = `RTL_TIMEOUT_CYC
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [4:0] my_address_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic ifc_in,
    input wire logic ren_in,
    input wire logic trigger_enable_cmd_in,
    input wire logic msg_busy_in,
    input wire logic msg_start_in,
    input wire logic msg_setting_in,
    input wire logic msg_pending_in,
    input wire logic panel_setting_key_in,
    input wire logic panel_multi_key_in,
    input wire logic panel_entry_done_in,
    input wire logic reading_available_in,
    input wire logic waiting_trigger_in,
    input wire logic poll_read_in,
    input wire logic error_query_in,
    input wire logic cmd_error_in,
    output logic listener_active_out,
    output logic talker_active_out,
    output logic addressed_light_out,
    output logic remote_light_out,
    output gpib_rl_pkg::rl_state_e rl_state_out,
    output logic accept_bus_cmd_out,
    output logic exec_allowed_out,
    output logic local_error_out,
    output logic device_clear_out,
    output logic trigger_out,
    output logic serial_poll_mode_out,
    output logic send_output_data_out,
    output logic rtl_out,
    output logic srq_out,
    output logic [7:0] status_byte_out,
    output logic [9:0] error_code_out
);
    import gpib_rl_pkg::*;

    typedef struct packed {
        logic listen;
        logic talk;
        logic spoll;
        rl_state_e rl;
        logic exec_remote;
        logic rtl;
        logic [31:0] rtl_timer;
        logic ev_power;
        logic ev_get;
        logic ev_local;
        logic ev_rtl;
        logic dcl;
        logic trig;
        logic lerr;
        logic [9:0] err_code;
    } state_s;

    state_s cur;
    state_s next_cur;

    // one-cycle strobes decoded from the command byte, then derived event, remote and status byte signals
    logic atn_cmd;
    logic is_mla;
    logic is_mta;
    logic is_unl;
    logic is_unt;
    logic is_spe;
    logic is_spd;
    logic is_get;
    logic is_llo;
    logic is_gtl;
    logic is_dcl;
    logic is_sdc;
    logic do_clear;
    logic any_event;
    logic rl_remote;
    logic [7:0] class_byte;
    logic [7:0] dev_byte;

    assign atn_cmd = cmd_valid_in;
    assign is_mla = atn_cmd &&
        (cmd_byte_in == (`LISTEN_BASE | {3'h0, my_address_in}));
    assign is_mta = atn_cmd &&
        (cmd_byte_in == (`TALK_BASE | {3'h0, my_address_in}));
    assign is_unl = atn_cmd && (cmd_byte_in == `CMD_UNL);
    assign is_unt = atn_cmd && (cmd_byte_in == `CMD_UNT);
    assign is_spe = atn_cmd && (cmd_byte_in == `CMD_SPE);
    assign is_spd = atn_cmd && (cmd_byte_in == `CMD_SPD);
    assign is_get = atn_cmd && (cmd_byte_in == `CMD_GET);
    assign is_llo = atn_cmd && (cmd_byte_in == `CMD_LLO);
    assign is_gtl = atn_cmd && (cmd_byte_in == `CMD_GTL);
    assign is_dcl = atn_cmd && (cmd_byte_in == `CMD_DCL);
    assign is_sdc = atn_cmd && (cmd_byte_in == `CMD_SDC);
    // sdc only counts while addressed to listen; dcl is universal
    assign do_clear = is_dcl ||
        (is_sdc && cur.listen);
    assign any_event = cur.ev_power | cur.ev_get | cur.ev_local | cur.ev_rtl;
    assign rl_remote = (cur.rl == REMS) || (cur.rl == RWLS);

    always_comb begin
        next_cur = cur;
        next_cur.dcl = 1'b0;
        next_cur.trig = 1'b0;
        next_cur.lerr = 1'b0;

        // clears come first, so an event set later in the same cycle wins
        if (poll_read_in || error_query_in) begin
            if (cur.ev_power) begin
                next_cur.ev_power = 1'b0;
            end else if (cur.ev_rtl) begin
                next_cur.ev_rtl = 1'b0;
            end else if (cur.ev_local) begin
                next_cur.ev_local = 1'b0;
            end else if (cur.ev_get) begin
                next_cur.ev_get = 1'b0;
            end
        end

        // error query reports the event it retires
        if (error_query_in) begin
            if (cur.ev_power) begin
                next_cur.err_code = `ERR_POWER_ON;
            end else if (cur.ev_rtl) begin
                next_cur.err_code = `ERR_RTL_LOST;
            end else if (cur.ev_local) begin
                next_cur.err_code = `ERR_LOCAL;
            end else if (cur.ev_get) begin
                next_cur.err_code = `ERR_GET_IGN;
            end else begin
                next_cur.err_code = `ERR_NONE;
            end
        end

        // power-on event survives a device clear
        if (do_clear) begin
            next_cur.dcl = 1'b1;
            next_cur.ev_get = 1'b0;
            next_cur.ev_local = 1'b0;
            next_cur.ev_rtl = 1'b0;
        end

        if (is_unl) begin
            next_cur.listen = 1'b0;
        end
        if (is_unt) begin
            next_cur.talk = 1'b0;
        end
        if (is_mla) begin
            next_cur.listen = 1'b1;
        end
        if (is_mta) begin
            next_cur.talk = 1'b1;
        end
        if (is_spe) begin
            next_cur.spoll = 1'b1;
        end
        if (is_spd) begin
            next_cur.spoll = 1'b0;
        end

        // a trigger refused while unaddressed leaves no trace
        if (is_get) begin
            if (cur.listen && trigger_enable_cmd_in &&
                !msg_busy_in && rl_remote) begin
                next_cur.trig = 1'b1;
            end else if (cur.listen) begin
                next_cur.ev_get = 1'b1;
            end
        end

        // lockout and go-to-local touch only the state, never the address
        if (is_llo) begin
            if (cur.rl == LOCS) begin
                next_cur.rl = LWLS;
            end else if (cur.rl == REMS) begin
                next_cur.rl = RWLS;
            end
        end

        if (is_gtl && cur.listen) begin
            if (cur.rl == REMS) begin
                next_cur.rl = LOCS;
            end else if (cur.rl == RWLS) begin
                next_cur.rl = LWLS;
            end
        end

        // rtl blocks going remote only from LOCS
        if (is_mla && ren_in) begin
            if (cur.rl == LOCS && !cur.rtl) begin
                next_cur.rl = REMS;
            end else if (cur.rl == LWLS) begin
                next_cur.rl = RWLS;
            end
        end

        // applied after addressing so it overrides a same-cycle address
        if (ifc_in) begin
            next_cur.listen = 1'b0;
            next_cur.talk = 1'b0;
        end

        // rtl: setting keys only; display keys never reach this input
        if (panel_setting_key_in && cur.rl != RWLS && cur.rl != LWLS) begin
            next_cur.rtl = panel_multi_key_in;
            next_cur.rtl_timer = 32'h0;
            if (cur.rl == REMS) begin
                next_cur.rl = LOCS;
                if (msg_pending_in) begin
                    next_cur.ev_rtl = 1'b1;
                end
            end
        end else if (cur.rtl) begin
            // stuck multi-key entry would otherwise lock out remote forever
            if (panel_entry_done_in || cur.rtl_timer >= (RTL_TIMEOUT_CYCLES - 1)) begin
                next_cur.rtl = 1'b0;
            end else begin
                next_cur.rtl_timer = cur.rtl_timer + 32'h1;
            end
        end

        if (!ren_in) begin
            next_cur.rl = LOCS;
        end
        // remote-ness latched at message start so mid-message REN/GTL have no effect
        if (msg_start_in) begin
            next_cur.exec_remote = (next_cur.rl == REMS || next_cur.rl == RWLS);
        end

        if (cur.rl == REMS && next_cur.rl == LOCS && panel_setting_key_in) begin
            next_cur.exec_remote = 1'b0;
        end

        // a bus setting while exec_remote is clear is refused and queued as an event
        if (msg_setting_in && !cur.exec_remote) begin
            next_cur.lerr = 1'b1;
            next_cur.ev_local = 1'b1;
        end
        if (cmd_error_in) begin
            next_cur.ev_local = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur <= '{
                listen: 1'b0,
                talk: 1'b0,
                spoll: 1'b0,
                rl: LOCS,
                exec_remote: 1'b0,
                rtl: 1'b0,
                rtl_timer: 32'h0,
                ev_power: 1'b1,
                ev_get: 1'b0,
                ev_local: 1'b0,
                ev_rtl: 1'b0,
                dcl: 1'b0,
                trig: 1'b0,
                lerr: 1'b0,
                err_code: `ERR_NONE
            };
        end else begin
            cur <= next_cur;
        end
    end

    always_comb begin
        dev_byte = `STB_DEVSTAT;
        if (waiting_trigger_in) begin
            dev_byte = dev_byte | `STB_WAIT_TRIG;
        end
        if (reading_available_in) begin
            dev_byte = dev_byte | `STB_READING;
        end
        // class of the top pending event, else live device status
        if (cur.ev_power) begin
            class_byte = `STB_POWER_ON;
        end else if (cur.ev_rtl) begin
            class_byte = `STB_RTL_LOST;
        end else if (cur.ev_local) begin
            class_byte = `STB_LOCAL_ERR;
        end else if (cur.ev_get) begin
            class_byte = `STB_GET_IGN;
        end else begin
            class_byte = dev_byte;
        end
        // busy is a live input, so the offset follows it without delay
        if (msg_busy_in) begin
            class_byte = class_byte + `BUSY_OFFSET;
        end
    end

    // levels decoded from the state register; status_byte_out also follows live inputs

    assign listener_active_out = cur.listen;
    assign talker_active_out = cur.talk;
    assign addressed_light_out = cur.listen | cur.talk;
    assign remote_light_out = (cur.rl == REMS) || (cur.rl == RWLS);
    assign rl_state_out = cur.rl;
    assign accept_bus_cmd_out = cur.listen;
    assign exec_allowed_out = cur.exec_remote;
    assign local_error_out = cur.lerr;
    assign device_clear_out = cur.dcl;
    assign trigger_out = cur.trig;
    assign serial_poll_mode_out = cur.spoll;
    assign send_output_data_out = cur.talk && !cur.spoll;
    assign rtl_out = cur.rtl;
    assign srq_out = any_event;
    assign status_byte_out = class_byte;
    assign error_code_out = cur.err_code;
endmodule : gpib_remote_local_status

// *** src/gpib_rl_params.svh ***
// constants for the remote/local and status block
// assumes inclusion by the package, the design file, the checker and the testbench
`ifndef GPIB_RL_PARAMS_SVH
`define GPIB_RL_PARAMS_SVH
`define CMD_GTL 8'h01
`define CMD_SDC 8'h04
`define CMD_GET 8'h08
`define CMD_LLO 8'h11
`define CMD_DCL 8'h14
`define CMD_SPE 8'h18
`define CMD_SPD 8'h19
`define CMD_UNL 8'h3f
`define CMD_UNT 8'h5f
`define LISTEN_BASE 8'h20
`define TALK_BASE 8'h40
`define BUSY_OFFSET 8'h10
`define STB_DEVSTAT 8'h80
`define STB_WAIT_TRIG 8'h08
`define STB_READING 8'h04
`define STB_NONE 8'h80
`define STB_POWER_ON 8'h41
`define STB_GET_IGN 8'h62
`define STB_LOCAL_ERR 8'h62
`define STB_RTL_LOST 8'h62
`define ERR_NONE 10'h000
`define ERR_POWER_ON 10'h191
`define ERR_LOCAL 10'h0c9
`define ERR_RTL_LOST 10'h0ca
`define ERR_GET_IGN 10'h0ce
`define CLK_HZ 25000000
`define RTL_TIMEOUT_MS 7500
`define RTL_TIMEOUT_CYC ((`CLK_HZ / 1000) * `RTL_TIMEOUT_MS)
`endif

// *** src/gpib_rl_pkg.sv ***
// types for the remote/local and status block
// assumes the params header is on the include path
`include "gpib_rl_params.svh"
package gpib_rl_pkg;
    typedef enum logic [1:0] {LOCS, LWLS, REMS, RWLS} rl_state_e;
endpackage : gpib_rl_pkg

// *** dv/gpib_ctrl_model.sv ***
// controller side model: ATN command bytes, ren and ifc lines
// assumes the bench calls its tasks; it drives just after falling edges
module gpib_ctrl_model (
    input wire logic clock_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_byte_out,
    output logic ifc_out,
    output logic ren_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid_out, ifc_out, ren_out} = 3'h0;
        cmd_byte_out = 8'hff;
    end
    // off the strobe the byte shows inverted, never the last value
    task automatic send(input logic [7:0] b);
        @(negedge clock_in);
        cmd_valid_out = 1'b1;
        cmd_byte_out = b;
        @(negedge clock_in);
        cmd_valid_out = 1'b0;
        cmd_byte_out = ~b;
    endtask : send
    task automatic lines(input logic r, input logic i);
        @(negedge clock_in);
        ren_out = r;
        ifc_out = i;
    endtask : lines
endmodule : gpib_ctrl_model

// *** dv/gpib_remote_local_status_chk.sv ***
// checker: port timing of the remote/local block
// assumes a bind onto the design top, one clock domain
`include "gpib_rl_params.svh"
module gpib_remote_local_status_chk
    import gpib_rl_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic cmd_valid_in,
    input wire logic ifc_in,
    input wire logic ren_in,
    input wire logic trigger_enable_cmd_in,
    input wire logic [4:0] my_address_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic listener_active_out,
    input wire logic talker_active_out,
    input wire logic addressed_light_out,
    input wire logic remote_light_out,
    input wire logic device_clear_out,
    input wire logic trigger_out,
    input wire gpib_rl_pkg::rl_state_e rl_state_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // ifc wins over an address byte in its cycle; bytes sent with ifc are left out of every check
    logic c;
    assign c = cmd_valid_in && !ifc_in;
    property p_unl; c && cmd_byte_in == `CMD_UNL |=> !listener_active_out; endproperty
    a_unl: assert property (p_unl) else $error("listener after unlisten");
    property p_unt; c && cmd_byte_in == `CMD_UNT |=> !talker_active_out; endproperty
    a_unt: assert property (p_unt) else $error("talker after untalk");
    property p_ifc; ifc_in |=> !(listener_active_out || talker_active_out || addressed_light_out); endproperty
    a_ifc: assert property (p_ifc) else $error("addressed after ifc");
    property p_llo; c && ren_in && cmd_byte_in == `CMD_LLO && rl_state_out == LOCS |=> rl_state_out == LWLS; endproperty
    a_llo: assert property (p_llo) else $error("lockout missed");
    property p_mla; c && ren_in && cmd_byte_in == ({3'h1, my_address_in}) && rl_state_out == LWLS
        |=> rl_state_out == RWLS; endproperty
    a_mla: assert property (p_mla) else $error("listen address did not go remote");
    property p_ren; !ren_in [*2] |-> rl_state_out == LOCS; endproperty
    a_ren: assert property (p_ren) else $error("not local with ren false");
    property p_lamp; remote_light_out == (rl_state_out inside {REMS, RWLS}); endproperty
    a_lamp: assert property (p_lamp) else $error("remote light wrong");
    property p_dcl; c && cmd_byte_in == `CMD_DCL |=> device_clear_out; endproperty
    a_dcl: assert property (p_dcl) else $error("device clear missed");
    property p_sdc; c && cmd_byte_in == `CMD_SDC && !listener_active_out |=> !device_clear_out; endproperty
    a_sdc: assert property (p_sdc) else $error("selected clear while unaddressed");
    property p_get; c && cmd_byte_in == `CMD_GET && !(listener_active_out && trigger_enable_cmd_in)
        |=> !trigger_out; endproperty
    a_get: assert property (p_get) else $error("trigger while not allowed");
endmodule : gpib_remote_local_status_chk
bind gpib_remote_local_status gpib_remote_local_status_chk chk (.*);

// *** dv/gpib_remote_local_status_test.sv ***
// testbench: one task per scenario for the remote/local block
// assumes the controller model and bound checker are compiled first
`include "gpib_rl_params.svh"
module gpib_remote_local_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gpib_rl_pkg::*;
    logic clock_in, resetn_in, cmd_valid_in, ifc_in, ren_in, trigger_enable_cmd_in, msg_busy_in;
    logic msg_start_in, msg_setting_in, msg_pending_in, panel_setting_key_in, panel_multi_key_in;
    logic panel_entry_done_in, reading_available_in, waiting_trigger_in, poll_read_in, error_query_in;
    logic cmd_error_in, listener_active_out, talker_active_out, addressed_light_out, remote_light_out;
    logic accept_bus_cmd_out, exec_allowed_out, local_error_out, device_clear_out, trigger_out;
    logic serial_poll_mode_out, send_output_data_out, rtl_out, srq_out;
    logic [4:0] my_address_in;
    logic [7:0] cmd_byte_in, status_byte_out;
    logic [9:0] error_code_out;
    rl_state_e rl_state_out;
    int n_fail = 0, samples_checked = 0, cycles = 0;
    localparam logic [7:0] MLA = 8'h25, MTA = 8'h45;
    // short rtl timeout keeps the run brief
    gpib_remote_local_status #(.RTL_TIMEOUT_CYCLES(20)) dut (.*);
    gpib_ctrl_model ctl (.clock_in(clock_in), .cmd_valid_out(cmd_valid_in), .cmd_byte_out(cmd_byte_in),
        .ifc_out(ifc_in), .ren_out(ren_in));
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clock_in);
        s = 1'b1;
        @(negedge clock_in);
        s = 1'b0;
    endtask : pulse
    task automatic t_events();
        chk("srq", 10'(srq_out), 10'h1);
        pulse(error_query_in);
        chk("err", error_code_out, 10'h191);
        pulse(msg_start_in);
        chk("exec", 10'(exec_allowed_out), 10'h0);
        pulse(msg_setting_in);
        chk("lerr", 10'({local_error_out, srq_out}), 10'h3);
        pulse(error_query_in);
        chk("err2", 10'({error_code_out, srq_out}), 10'h192);
    endtask : t_events
    task automatic t_addr();
        ctl.lines(1'b1, 1'b0);
        ctl.send(MLA);
        chk("lsn", 10'({listener_active_out, addressed_light_out, rl_state_out}), 10'h0e);
        ctl.send(MTA);
        ctl.send(`CMD_UNT);
        chk("tlk", 10'(talker_active_out), 10'h0);
        ctl.send(`CMD_UNL);
        chk("unl", 10'({listener_active_out, accept_bus_cmd_out}), 10'h0);
        ctl.send(MLA);
        ctl.send(MTA);
        ctl.lines(1'b1, 1'b1);
        ctl.lines(1'b1, 1'b0);
        chk("ifc", 10'({listener_active_out, talker_active_out, addressed_light_out}), 10'h0);
    endtask : t_addr
    task automatic t_lock();
        ctl.lines(1'b0, 1'b0);
        ctl.lines(1'b1, 1'b0);
        chk("loc", 10'({remote_light_out, rl_state_out}), 10'(LOCS));
        ctl.send(`CMD_LLO);
        chk("llo", 10'(rl_state_out), 10'(LWLS));
        ctl.send(MLA);
        pulse(panel_setting_key_in);
        ctl.send(`CMD_UNL);
        ctl.send(`CMD_GTL);
        chk("rwls", 10'(rl_state_out), 10'(RWLS));
        ctl.send(MLA);
        ctl.send(`CMD_GTL);
        chk("gtl", 10'(rl_state_out), 10'(LWLS));
        ctl.lines(1'b0, 1'b0);
        ctl.lines(1'b1, 1'b0);
        ctl.send(MLA);
        chk("rems", 10'(rl_state_out), 10'(REMS));
    endtask : t_lock
    task automatic t_trig();
        trigger_enable_cmd_in = 1'b1;
        ctl.send(`CMD_GET);
        chk("trg", 10'(trigger_out), 10'h1);
        trigger_enable_cmd_in = 1'b0;
        ctl.send(`CMD_GET);
        chk("ign", 10'({trigger_out, srq_out, status_byte_out}), 10'h162);
        msg_busy_in = 1'b1;
        @(negedge clock_in);
        chk("busy", 10'(status_byte_out), 10'h072);
        msg_busy_in = 1'b0;
        ctl.send(`CMD_DCL);
        chk("dcl", 10'({device_clear_out, srq_out}), 10'h2);
        ctl.send(`CMD_UNL);
        ctl.send(`CMD_SDC);
        chk("sdc", 10'(device_clear_out), 10'h0);
    endtask : t_trig
    task automatic t_poll();
        ctl.send(MTA);
        ctl.send(`CMD_SPE);
        chk("spe", 10'({serial_poll_mode_out, send_output_data_out}), 10'h2);
        ctl.send(`CMD_SPD);
        chk("spd", 10'({serial_poll_mode_out, send_output_data_out}), 10'h1);
        {reading_available_in, waiting_trigger_in} = 2'h3;
        @(negedge clock_in);
        chk("stb", 10'(status_byte_out), 10'h08c);
        {reading_available_in, waiting_trigger_in} = 2'h0;
    endtask : t_poll
    task automatic t_rtl();
        panel_multi_key_in = 1'b1;
        pulse(panel_setting_key_in);
        panel_multi_key_in = 1'b0;
        chk("rtl", 10'({rtl_out, remote_light_out, rl_state_out}), 10'(4'h8));
        repeat (10) @(negedge clock_in);
        chk("hold", 10'(rtl_out), 10'h1);
        repeat (15) @(negedge clock_in);
        chk("tmo", 10'(rtl_out), 10'h0);
    endtask : t_rtl
    task automatic t_exec();
        ctl.send(MLA);
        pulse(msg_start_in);
        chk("exec1", 10'(exec_allowed_out), 10'h1);
        ctl.lines(1'b0, 1'b0);
        pulse(msg_setting_in);
        chk("midren", 10'({local_error_out, exec_allowed_out, rl_state_out}), 10'h4);
        ctl.lines(1'b1, 1'b0);
        pulse(cmd_error_in);
        chk("cerr", 10'({srq_out, status_byte_out}), 10'h162);
        @(negedge clock_in);
        poll_read_in = 1'b1;
        cmd_error_in = 1'b1;
        @(negedge clock_in);
        poll_read_in = 1'b0;
        cmd_error_in = 1'b0;
        chk("setwin", 10'(srq_out), 10'h1);
        pulse(poll_read_in);
        chk("polled", 10'(srq_out), 10'h0);
        panel_multi_key_in = 1'b1;
        pulse(panel_setting_key_in);
        panel_multi_key_in = 1'b0;
        chk("rtl2", 10'(rtl_out), 10'h1);
        pulse(panel_entry_done_in);
        chk("done", 10'(rtl_out), 10'h0);
    endtask : t_exec
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    initial begin
        resetn_in = 1'b0;
        my_address_in = 5'h05;
        {trigger_enable_cmd_in, msg_busy_in, msg_start_in, msg_setting_in, msg_pending_in} = 5'h0;
        {panel_setting_key_in, panel_multi_key_in, panel_entry_done_in, reading_available_in} = 4'h0;
        {waiting_trigger_in, poll_read_in, error_query_in, cmd_error_in} = 4'h0;
        repeat (2) @(negedge clock_in);
        resetn_in = 1'b1;
        t_events();
        t_addr();
        t_lock();
        t_trig();
        t_poll();
        t_rtl();
        t_exec();
        end_of_test();
    end
endmodule : gpib_remote_local_status_test
